// File: design/eiw_ctrl.sv
// external interrupt controller: sensing, flags, priority, nesting and power-down wake
//
// What this block does
// R1: entering any handler clears the global enable so nothing else is taken until it is set again.
// R2: setting the global enable inside a handler lets another enabled pending request be taken at once.
// R3: an enabled pin is still sensed while it is driven as an output, giving a software interrupt.
// R4: pin-change group zero raises one request when any of its eight enabled lines toggles.
// R5: a pin-change line requests on both rising and falling transitions, once per transition.
// R6: external interrupt zero in level mode wakes the device from power-down and its handler runs.
// R7: sense select 00 is low level, 01 any edge, 10 falling edge, 11 rising edge.
// R8: edge-sensed pins are sampled on the clock, pulses longer than one period always request while running, never in power-down.
// R9: simultaneous requests are served lowest vector first, zero ahead of one.
// R10: a flag raised while the global enable is clear stays pending until the enable returns, unless the flags register is read.
`timescale 1ns/100ps
module eiw_ctrl #(
	parameter int PC_LINES = 8,
	parameter int DEPTH_W  = 4
) (
	input  wire logic                clk_i,
	input  wire logic                rst_i,
	input  wire logic                ce_i,
	input  wire logic                wb_cyc_i,
	input  wire logic                wb_stb_i,
	input  wire logic                wb_we_i,
	input  wire logic [7:0]          wb_adr_i,
	input  wire logic [3:0]          wb_sel_i,
	input  wire logic [31:0]         wb_dat_i,
	output logic      [31:0]         wb_dat_o,
	output logic                     wb_ack_o,
	input  wire logic [1:0]          ext_pin_i,
	input  wire logic [PC_LINES-1:0] pc_pin_i,
	input  wire logic                irq_ack_i,
	input  wire logic                irq_ret_i,
	input  wire logic                sleep_req_i,
	output logic                     irq_req_o,
	output logic      [1:0]          irq_vec_o,
	output logic                     awake_o,
	output logic                     irq_o
);
	logic                gie_q;
	logic [3:0]          sense_q;
	logic [2:0]          enable_q;
	logic [PC_LINES-1:0] pcmask_q;
	logic [2:0]          flags_q;
	logic [2:0]          flags_d;
	logic [2:0]          imask_q;
	logic [DEPTH_W-1:0]  depth_q;
	logic                ack_q;
	logic [31:0]         dat_q;
	eiw_pkg::eiw_pwr_t   pwr_q;

	logic [1:0]          ext_lvl;
	logic [1:0]          ext_rise;
	logic [1:0]          ext_fall;
	logic [PC_LINES-1:0] pc_lvl;
	logic [PC_LINES-1:0] pc_rise;
	logic [PC_LINES-1:0] pc_fall;

	// pads are read straight from the pin, whatever its direction, so driving the pin raises a request
	eiw_pin_sync #(.W(2)) u_ext_sync ( // R3 R8
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.ce_i    (ce_i),
		.pin_i   (ext_pin_i),
		.level_o (ext_lvl),
		.rise_o  (ext_rise),
		.fall_o  (ext_fall)
	);

	eiw_pin_sync #(.W(PC_LINES)) u_pc_sync ( // R3
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.ce_i    (ce_i),
		.pin_i   (pc_pin_i),
		.level_o (pc_lvl),
		.rise_o  (pc_rise),
		.fall_o  (pc_fall)
	);

	// bus decode
	wire       running   = (pwr_q == eiw_pkg::ST_RUN);
	wire       bus_req   = wb_cyc_i & wb_stb_i;
	wire       bus_take  = bus_req & ack_q & ce_i;
	wire       wr_lo     = bus_take & wb_we_i & wb_sel_i[0];
	wire       wr_core   = wr_lo & (wb_adr_i == eiw_pkg::OFS_CORE);
	wire       wr_sense  = wr_lo & (wb_adr_i == eiw_pkg::OFS_SENSE);
	wire       wr_enable = wr_lo & (wb_adr_i == eiw_pkg::OFS_ENABLE);
	wire       wr_pcmask = wr_lo & (wb_adr_i == eiw_pkg::OFS_PCMASK);
	wire       wr_imask  = wr_lo & (wb_adr_i == eiw_pkg::OFS_IMASK);
	wire       rd_flags  = bus_take & ~wb_we_i & (wb_adr_i == eiw_pkg::OFS_FLAGS);

	// per-channel sense decode; a level request carries no flag, it lasts while the pin is low
	logic [1:0] ext_edge;
	logic [1:0] ext_level_req;
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_sense
			wire [1:0] sel = sense_q[gi*eiw_pkg::SENSE_W +: eiw_pkg::SENSE_W];
			assign ext_level_req[gi] = (sel == eiw_pkg::SENSE_LOW) & ~ext_lvl[gi]; // R7
			assign ext_edge[gi] = ((sel == eiw_pkg::SENSE_ANY)  & (ext_rise[gi] | ext_fall[gi])) | // R7
			                      ((sel == eiw_pkg::SENSE_FALL) & ext_fall[gi]) |
			                      ((sel == eiw_pkg::SENSE_RISE) & ext_rise[gi]);
		end
	endgenerate

	// pin-change lines are sensed without the clock in a real part, so they also act in power-down
	wire pc_toggle = |((pc_rise | pc_fall) & pcmask_q); // R4 R5
	// edge sampling needs the core clock, which power-down stops
	wire [2:0] flag_set = {pc_toggle, ext_edge & {2{running}}}; // R8

	wire [2:0] pend = enable_q & (flags_q | {1'b0, ext_level_req});

	// fixed priority by vector number
	assign irq_vec_o = pend[eiw_pkg::BIT_EXT0] ? eiw_pkg::VEC_EXT0 : // R9
	                   pend[eiw_pkg::BIT_EXT1] ? eiw_pkg::VEC_EXT1 :
	                   pend[eiw_pkg::BIT_PCG0] ? eiw_pkg::VEC_PCG0 : eiw_pkg::VEC_NONE;
	assign irq_req_o = gie_q & running & (|pend); // R2 R10
	assign awake_o   = running;

	wire       taking  = irq_ack_i & irq_req_o & ce_i;
	wire [2:0] take_oh = {irq_vec_o == eiw_pkg::VEC_PCG0, irq_vec_o == eiw_pkg::VEC_EXT1,
	                      irq_vec_o == eiw_pkg::VEC_EXT0} & {3{taking}};

	// a new event in the clearing cycle wins over both the read clear and the handler-entry clear
	always_comb begin
		flags_d = flags_q;
		if (rd_flags) begin
			flags_d = '0;
		end
		flags_d = (flags_d & ~take_oh) | flag_set; // R10
	end

	wire wake = (enable_q[eiw_pkg::BIT_EXT0] & ext_level_req[0]) | // R6
	            (enable_q[eiw_pkg::BIT_EXT1] & ext_level_req[1]) |
	            (enable_q[eiw_pkg::BIT_PCG0] & flags_q[eiw_pkg::BIT_PCG0]);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pwr_q <= eiw_pkg::ST_RUN;
		end else if (ce_i) begin
			unique case (pwr_q)
				eiw_pkg::ST_RUN: begin
					if (sleep_req_i) begin
						pwr_q <= eiw_pkg::ST_DOWN;
					end
				end
				eiw_pkg::ST_DOWN: begin
					if (wake) begin
						pwr_q <= eiw_pkg::ST_RUN; // R6
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			gie_q <= eiw_pkg::GIE_RST;
		end else if (ce_i) begin
			if (taking) begin
				gie_q <= 1'b0; // R1
			end else if (wr_core) begin
				gie_q <= wb_dat_i[eiw_pkg::BIT_GIE]; // R2
			end else if (irq_ret_i) begin
				gie_q <= 1'b1;
			end
		end
	end

	// nesting depth saturates at both ends so an unbalanced return cannot wrap it
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			depth_q <= '0;
		end else if (ce_i) begin
			if (taking && !irq_ret_i && depth_q != '1) begin
				depth_q <= depth_q + 1'b1;
			end else if (irq_ret_i && !taking && depth_q != '0) begin
				depth_q <= depth_q - 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sense_q  <= eiw_pkg::SENSE_RST;
			enable_q <= eiw_pkg::ENABLE_RST;
			pcmask_q <= PC_LINES'(eiw_pkg::PCMASK_RST);
			imask_q  <= eiw_pkg::IMASK_RST;
			flags_q  <= eiw_pkg::FLAGS_RST;
		end else if (ce_i) begin
			flags_q <= flags_d;
			if (wr_sense) begin
				sense_q <= wb_dat_i[3:0];
			end
			if (wr_enable) begin
				enable_q <= wb_dat_i[2:0];
			end
			if (wr_pcmask) begin
				pcmask_q <= wb_dat_i[PC_LINES-1:0];
			end
			if (wr_imask) begin
				imask_q <= wb_dat_i[2:0];
			end
		end
	end

	// read mux, unmapped offsets read zero
	wire [31:0] rdata =
		(wb_adr_i == eiw_pkg::OFS_CORE)   ? {31'h0000_0000, gie_q} :
		(wb_adr_i == eiw_pkg::OFS_SENSE)  ? {28'h000_0000, sense_q} :
		(wb_adr_i == eiw_pkg::OFS_ENABLE) ? {29'h000_0000, enable_q} :
		(wb_adr_i == eiw_pkg::OFS_PCMASK) ? 32'(pcmask_q) :
		(wb_adr_i == eiw_pkg::OFS_FLAGS)  ? {29'h000_0000, flags_q} :
		(wb_adr_i == eiw_pkg::OFS_IMASK)  ? {29'h000_0000, imask_q} :
		(wb_adr_i == eiw_pkg::OFS_STATE)  ? 32'({depth_q, ext_lvl, ~running, irq_req_o}) :
		32'h0000_0000;

	// registered ack: one wait state, every access answered, ack drops after one cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			dat_q <= 32'h0000_0000;
		end else if (ce_i) begin
			ack_q <= bus_req & ~ack_q;
			if (bus_req && !ack_q) begin
				dat_q <= rdata;
			end
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;
	assign irq_o    = |(flags_q & imask_q);

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_entry_clears_gie: assert property (taking |=> !gie_q) // R1
		else $error("global enable still set after handler entry");
	// flags only: a level request may lawfully vanish, and a sleep request may stop the core
	a_nested_request: assert property ((ce_i && wr_core && wb_dat_i[0] && !taking && running && !sleep_req_i
		&& (|(enable_q & flags_q))) |=> irq_req_o) // R2
		else $error("pending request not presented after enable set");
	a_pc_toggle_flag: assert property ((ce_i && pc_toggle) |=> flags_q[eiw_pkg::BIT_PCG0]) // R4
		else $error("pin change toggle did not set group flag");
	a_pc_both_edges: assert property ((ce_i && (|(pc_fall & pcmask_q)) && !rd_flags)
		|=> flags_q[eiw_pkg::BIT_PCG0]) // R5
		else $error("falling pin change lost");
	a_level_wake: assert property ((!running && ce_i && enable_q[0] && ext_level_req[0])
		|=> running && (!gie_q || !ext_level_req[0] || (irq_req_o && irq_vec_o == eiw_pkg::VEC_EXT0))) // R6
		else $error("level on zero did not wake and request");
	a_rise_sense: assert property ((ce_i && running && sense_q[1:0] == eiw_pkg::SENSE_RISE && ext_rise[0])
		|=> flags_q[eiw_pkg::BIT_EXT0]) // R7
		else $error("rising edge not flagged");
	a_low_noflag: assert property ((ce_i && sense_q[1:0] == eiw_pkg::SENSE_LOW && !flags_q[0])
		|=> !flags_q[eiw_pkg::BIT_EXT0]) // R7
		else $error("level mode set an edge flag");
	a_pulse_caught: assert property ((ce_i && running && sense_q[1:0] == eiw_pkg::SENSE_FALL
		&& !ext_pin_i[0] && ext_lvl[0]) ##1 (ce_i && running && !ext_pin_i[0] && !rd_flags && !taking)[*2]
		|=> flags_q[eiw_pkg::BIT_EXT0]) // R8
		else $error("held falling pulse not flagged");
	a_priority_order: assert property ((irq_req_o && pend[0]) |-> irq_vec_o == eiw_pkg::VEC_EXT0) // R9
		else $error("vector zero not served first");
	a_flag_held: assert property ((flags_q[0] && !gie_q && !rd_flags) |=> flags_q[0]) // R10
		else $error("pending flag lost while disabled");
endmodule // eiw_ctrl

// File: design/eiw_pin_sync.sv
// two-flop pin synchroniser with edge detection
`timescale 1ns/100ps
module eiw_pin_sync #(
	parameter int W = 2
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic         ce_i,
	input  wire logic [W-1:0] pin_i,
	output logic      [W-1:0] level_o,
	output logic      [W-1:0] rise_o,
	output logic      [W-1:0] fall_o
);
	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;
	logic [W-1:0] prev_q;

	// resets to high so an idle pulled-up pin gives no edge at start
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_q <= '1;
			sync_q <= '1;
			prev_q <= '1;
		end else if (ce_i) begin
			meta_q <= pin_i;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	assign level_o = sync_q;
	assign rise_o  = sync_q & ~prev_q;
	assign fall_o  = ~sync_q & prev_q;
endmodule // eiw_pin_sync

// File: design/eiw_pkg.sv
// shared constants of the external interrupt, nesting and wake block
package eiw_pkg;
	// register byte offsets on the wishbone slave
	localparam logic [7:0] OFS_CORE   = 8'h00;
	localparam logic [7:0] OFS_SENSE  = 8'h04;
	localparam logic [7:0] OFS_ENABLE = 8'h08;
	localparam logic [7:0] OFS_PCMASK = 8'h0C;
	localparam logic [7:0] OFS_FLAGS  = 8'h10;
	localparam logic [7:0] OFS_IMASK  = 8'h14;
	localparam logic [7:0] OFS_STATE  = 8'h18;

	// field positions
	localparam int BIT_GIE     = 0;
	localparam int BIT_EXT0    = 0;
	localparam int BIT_EXT1    = 1;
	localparam int BIT_PCG0    = 2;
	localparam int SENSE_W     = 2;

	// reset values
	localparam logic       GIE_RST    = 1'h0;
	localparam logic [3:0] SENSE_RST  = 4'h0;
	localparam logic [2:0] ENABLE_RST = 3'h0;
	localparam logic [7:0] PCMASK_RST = 8'h00;
	localparam logic [2:0] FLAGS_RST  = 3'h0;
	localparam logic [2:0] IMASK_RST  = 3'h0;

	// sense select encodings {sense_select_high, sense_select_low}
	localparam logic [1:0] SENSE_LOW  = 2'h0;
	localparam logic [1:0] SENSE_ANY  = 2'h1;
	localparam logic [1:0] SENSE_FALL = 2'h2;
	localparam logic [1:0] SENSE_RISE = 2'h3;

	// vector numbers, lower number is higher priority
	localparam logic [1:0] VEC_NONE = 2'h0;
	localparam logic [1:0] VEC_EXT0 = 2'h1;
	localparam logic [1:0] VEC_EXT1 = 2'h2;
	localparam logic [1:0] VEC_PCG0 = 2'h3;

	typedef enum logic [1:0] {
		ST_RUN  = 2'b01,
		ST_DOWN = 2'b10
	} eiw_pwr_t;
endpackage

// File: tb/eiw_pin_model.sv
// switch-side model of the interrupt pins, with pull-ups on every line
`timescale 1ns/100ps
module eiw_pin_model (
	input  wire logic       clk_i,
	output logic      [1:0] ext_o,
	output logic      [7:0] pc_o
);
	initial begin
		ext_o = 2'h3;
		pc_o  = 8'hFF;
	end
	// each level stands for several cycles so the synchroniser always sees it
	task set_ext(input logic [1:0] v);
		@(posedge clk_i);
		ext_o <= v;
		repeat (4) @(posedge clk_i);
	endtask
	task tog_pc(input int i);
		@(posedge clk_i);
		pc_o[i] <= ~pc_o[i];
		repeat (4) @(posedge clk_i);
	endtask
endmodule // eiw_pin_model

// File: tb/testbench.sv
// self-checking bench of the external interrupt controller
`timescale 1ns/100ps
module testbench;
	logic        clk_i, rst_i, ce_i, sleep_req_i, irq_ack_i, irq_ret_i;
	logic [3:0]  wb_sel_i;
	logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic        irq_req_o, awake_o, irq_o;
	logic [7:0]  wb_adr_i, pc_pin;
	logic [31:0] wb_dat_i, wb_dat_o;
	logic [1:0]  irq_vec_o, ext_pin;
	int          err_total, checks;
	int unsigned k;
	logic [31:0] rq[$];
	logic [1:0]  vq[$];
	eiw_ctrl uut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .ext_pin_i(ext_pin), .pc_pin_i(pc_pin), .irq_ack_i(irq_ack_i),
		.irq_ret_i(irq_ret_i), .sleep_req_i(sleep_req_i), .irq_req_o(irq_req_o), .irq_vec_o(irq_vec_o),
		.awake_o(awake_o), .irq_o(irq_o));
	eiw_pin_model pins (.clk_i(clk_i), .ext_o(ext_pin), .pc_o(pc_pin));
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	// only the watchdog ends a wait for ack
	task wb(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [3:0] s);
		@(posedge clk_i);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i, wb_adr_i, wb_dat_i} <= {2'b11, w, s, a, d};
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		{wb_cyc_i, wb_stb_i} <= 2'b00;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		wb(a, 1'b1, d, 4'hF);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		rq.push_back(e);
		wb(a, 1'b0, 32'h0000_0000, 4'hF);
	endtask
	task rdf(input logic [31:0] e);
		rd(eiw_pkg::OFS_FLAGS, e);
	endtask
	// the core side: wait for a request, enter its handler, then look one cycle on
	task take(input logic [1:0] v);
		do @(posedge clk_i); while (irq_req_o !== 1'b1);
		vq.push_back(v);
		irq_ack_i <= 1'b1;
		@(posedge clk_i);
		irq_ack_i <= 1'b0;
		@(posedge clk_i);
		chk("request after entry", 32'h0000_0000, 32'(irq_req_o));
	endtask
	task pulse(input bit sleep);
		@(posedge clk_i);
		{sleep_req_i, irq_ret_i} <= {sleep, !sleep};
		@(posedge clk_i);
		{sleep_req_i, irq_ret_i} <= 2'b00;
	endtask
	task done(input string s);
		$display("test %s finished", s);
	endtask
	task stop_test;
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	always @(posedge clk_i) begin
		if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
			chk("read data", rq.pop_front(), wb_dat_o);
		if (irq_ack_i === 1'b1)
			chk("vector", 32'(vq.pop_front()), 32'(irq_vec_o));
	end
	initial begin
		repeat (20000) @(posedge clk_i);
		err_total++;
		stop_test;
	end
	initial begin
		{rst_i, sleep_req_i, irq_ack_i, irq_ret_i, wb_cyc_i, wb_stb_i, wb_we_i} = 7'h40;
		{ce_i, wb_sel_i} = 5'h1F;
		wb_adr_i = 8'h00;
		wb_dat_i = 32'h0000_0000;
		err_total = 0;
		checks = 0;
		void'($urandom(27777));
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		// offset 0x1c is unmapped and must read zero
		for (int a = 0; a < 32; a += 4)
			rd(8'(a), (a == 24) ? 32'h0000_000C : 32'h0000_0000);
		// a write whose lowest byte lane is off must leave the register alone
		wb(eiw_pkg::OFS_ENABLE, 1'b1, 32'h0000_0007, 4'(($urandom % 8) << 1));
		rd(eiw_pkg::OFS_ENABLE, 32'h0000_0000);
		done("reset");
		for (int i = 0; i < 2; i++)
			for (int m = 0; m < 4; m++) begin
				wr(eiw_pkg::OFS_SENSE, 32'(m << (2 * i)));
				pins.set_ext(2'(3 ^ (1 << i)));
				rdf((m == 1 || m == 2) ? 32'(1 << i) : 32'h0000_0000);
				pins.set_ext(2'h3);
				rdf((m == 1 || m == 3) ? 32'(1 << i) : 32'h0000_0000);
			end
		done("sense modes");
		k = $urandom % 8;
		wr(eiw_pkg::OFS_ENABLE, 32'h0000_0004);
		wr(eiw_pkg::OFS_PCMASK, 32'(1 << k));
		pins.tog_pc(k);
		rdf(32'h0000_0004);
		pins.tog_pc(k);
		rdf(32'h0000_0004);
		pins.tog_pc((k + 1) % 8);
		rdf(32'h0000_0000);
		done("pin change");
		wr(eiw_pkg::OFS_SENSE, 32'h0000_000F);
		wr(eiw_pkg::OFS_ENABLE, 32'h0000_0003);
		pins.set_ext(2'h0);
		pins.set_ext(2'h3);
		chk("request while disabled", 32'h0000_0000, 32'(irq_req_o));
		wr(eiw_pkg::OFS_CORE, 32'h0000_0001);
		take(eiw_pkg::VEC_EXT0);
		wr(eiw_pkg::OFS_CORE, 32'h0000_0001);
		take(eiw_pkg::VEC_EXT1);
		rd(eiw_pkg::OFS_STATE, 32'h0000_002C);
		pulse(1'b0);
		pulse(1'b0);
		rd(eiw_pkg::OFS_STATE, 32'h0000_000C);
		done("nesting");
		wr(eiw_pkg::OFS_ENABLE, 32'h0000_0000);
		wr(eiw_pkg::OFS_SENSE, 32'h0000_0001);
		pins.set_ext(2'h2);
		chk("masked irq", 32'h0000_0000, 32'(irq_o));
		wr(eiw_pkg::OFS_IMASK, 32'h0000_0001);
		@(posedge clk_i);
		chk("unmasked irq", 32'h0000_0001, 32'(irq_o));
		rdf(32'h0000_0001);
		@(posedge clk_i);
		chk("cleared irq", 32'h0000_0000, 32'(irq_o));
		// with the clock enable ce_i low the pin edge must wait, not be lost
		ce_i <= 1'b0;
		pins.set_ext(2'h3);
		chk("frozen irq", 32'h0000_0000, 32'(irq_o));
		ce_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		chk("thawed irq", 32'h0000_0001, 32'(irq_o));
		rdf(32'h0000_0001);
		pins.set_ext(2'h2);
		pins.set_ext(2'h3);
		rdf(32'h0000_0001);
		wr(eiw_pkg::OFS_IMASK, 32'h0000_0000);
		done("irq line");
		wr(eiw_pkg::OFS_SENSE, 32'h0000_0000);
		wr(eiw_pkg::OFS_ENABLE, 32'h0000_0001);
		pulse(1'b1);
		@(posedge clk_i);
		chk("asleep", 32'h0000_0000, 32'(awake_o));
		pins.set_ext(2'h2);
		take(eiw_pkg::VEC_EXT0);
		chk("woken", 32'h0000_0001, 32'(awake_o));
		pins.set_ext(2'h3);
		pulse(1'b0);
		done("wake");
		stop_test;
	end
endmodule // testbench
